// File: rtl/ifsb_params.svh
// Purpose: Constants for the interrupt flag status bank
// Assumes: Included by bare name from the modules; the package does not include it
// Notes:   Offsets are byte addresses on the register bus
`ifndef IFSB_PARAMS_SVH
`define IFSB_PARAMS_SVH

`define IFSB_OFS_WORD1     8'h00
`define IFSB_OFS_WORD2     8'h04
`define IFSB_OFS_WORD3     8'h08
`define IFSB_OFS_WORD4     8'h0C
`define IFSB_OFS_STAT      8'h10
`define IFSB_OFS_MASK      8'h14
`define IFSB_OFS_PEND      8'h18

`define IFSB_IMPL_WORD1    16'h0007
`define IFSB_IMPL_WORD2    16'h6FF3
`define IFSB_IMPL_WORD3    16'h6066
`define IFSB_IMPL_WORD4    16'h210E

`define IFSB_FLAG_RESET    16'h0000
`define IFSB_STAT_RESET    4'h0
`define IFSB_MASK_RESET    4'h0
`define IFSB_RDATA_RESET   32'h0000_0000

`define IFSB_BIT_CMP       2
`define IFSB_BIT_I2C1_M    1
`define IFSB_BIT_I2C1_S    0
`define IFSB_BIT_DMA4      14
`define IFSB_BIT_PPORT     13
`define IFSB_BIT_OC7       11
`define IFSB_BIT_OC6       10
`define IFSB_BIT_OC5       9
`define IFSB_BIT_IC6       8
`define IFSB_BIT_IC5       7
`define IFSB_BIT_IC4       6
`define IFSB_BIT_IC3       5
`define IFSB_BIT_DMA3      4
`define IFSB_BIT_SPI2_EV   1
`define IFSB_BIT_SPI2_FLT  0
`define IFSB_BIT_RTC       14
`define IFSB_BIT_DMA5      13
`define IFSB_BIT_EXT4      6
`define IFSB_BIT_EXT3      5
`define IFSB_BIT_I2C2_M    2
`define IFSB_BIT_I2C2_S    1
`define IFSB_BIT_CTMU      13
`define IFSB_BIT_LVD       8
`define IFSB_BIT_CRC       3
`define IFSB_BIT_U2ERR     2
`define IFSB_BIT_U1ERR     1

`endif

// File: rtl/ifsb_pkg.sv
// Purpose: Types shared by the interrupt flag status bank
// Assumes: Constants live in ifsb_params.svh
// Notes:   Event structs carry one-cycle request pulses
package ifsb_pkg;

   typedef logic [15:0] ifsb_word_t;

   typedef struct packed {
      logic comparator_flag;
      logic i2c1_master_flag;
      logic i2c1_slave_flag;
      logic dma_ch4_flag;
      logic parallel_port_flag;
      logic out_compare7_flag;
      logic out_compare6_flag;
      logic out_compare5_flag;
      logic in_capture6_flag;
      logic in_capture5_flag;
      logic in_capture4_flag;
      logic in_capture3_flag;
      logic dma_ch3_flag;
      logic spi2_event_flag;
      logic spi2_fault_flag;
      logic calendar_clock_flag;
      logic dma_ch5_flag;
      logic ext_pin4_flag;
      logic ext_pin3_flag;
      logic i2c2_master_flag;
      logic i2c2_slave_flag;
      logic charge_timer_flag;
      logic low_voltage_flag;
      logic crc_engine_flag;
      logic uart2_error_flag;
      logic uart1_error_flag;
   } ifsb_events_s;

   typedef struct packed {
      ifsb_word_t irq_flags_word4;
      ifsb_word_t irq_flags_word3;
      ifsb_word_t irq_flags_word2;
      ifsb_word_t irq_flags_word1;
   } ifsb_pend_s;

   typedef enum logic [3:0] {
      IFSB_IDLE = 4'b0001,
      IFSB_WR   = 4'b0010,
      IFSB_RDW  = 4'b0100,
      IFSB_RDD  = 4'b1000
   } ifsb_bus_e;

endpackage

// File: rtl/ifsb_flag_word.sv
// Purpose: One 16-bit word of sticky interrupt request flags
// Assumes: Events are one-cycle pulses on hclk
// Notes:   Unimplemented positions are never built
`include "ifsb_params.svh"

module ifsb_flag_word #(
   parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [15:0] event_in,
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   output logic [15:0]      flags,
   output logic             any_event
);
   import ifsb_pkg::*;

   localparam logic [15:0] FLAG_RST = `IFSB_FLAG_RESET;

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_bit
         if (IMPL_MASK[gi]) begin : g_impl
            always_ff @(posedge hclk or negedge hresetn) begin
               if (!hresetn) begin
                  flags[gi] <= FLAG_RST[gi]; // R11
               end else if (event_in[gi]) begin
                  flags[gi] <= 1'b1; // R12
               end else if (wr_en) begin
                  flags[gi] <= wr_data[gi]; // R10
               end
            end
         end else begin : g_none
            assign flags[gi] = 1'b0; // R09
         end
      end
   endgenerate

   // Ignore requests on positions that do not exist
   assign any_event = |(event_in & IMPL_MASK);

endmodule

// File: rtl/ifsb_top.sv
// Purpose: Interrupt request flag words 1..4 behind an AHB-Lite slave
// Assumes: Event sources run on hclk and pulse for one cycle
// Notes:   Writes take no wait state, reads take one
//
// Functional notes
// R01: Word 1 holds comparator bit 2, I2C1 master bit 1, slave bit 0.
// R02: Word 2 holds DMA4 14, parallel port 13, compare 7/6/5 at 11/10/9.
// R03: Word 2 holds capture 6/5/4/3 at bits 8..5, DMA3 at bit 4.
// R04: Word 2 holds SPI2 event bit 1, SPI2 fault bit 0.
// R05: Word 3 holds clock 14, DMA5 13, external pins 4/3 at 6/5.
// R06: Word 3 holds I2C2 master bit 2, I2C2 slave bit 1.
// R07: Word 4 holds CTMU 13, low voltage 8, CRC 3, UART2/1 error 2/1.
// R08: A flag reads one once its request occurred, else zero.
// R09: Unimplemented flag positions always read zero.
// R10: Software may read and write every implemented flag.
// R11: Reset clears every flag.
// R12: Flags stick until written zero; an event beats a same-cycle clear.
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`include "ifsb_params.svh"

module ifsb_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire ifsb_pkg::ifsb_events_s events,
   output ifsb_pkg::ifsb_pend_s      pending,
   output logic                      irq
);
   import ifsb_pkg::*;

   localparam int NW = 4;
   localparam int NSEL = 7;

   typedef logic [NSEL-1:0] ifsb_sel_t;

   ifsb_bus_e         state;
   ifsb_bus_e         next_state;
   logic [ADDR_W-1:0] addr_q;
   logic              accept;
   ifsb_sel_t         wsel;
   ifsb_sel_t         rsel;
   logic [15:0]       ev_vec   [NW];
   logic [15:0]       flag_q   [NW];
   logic [NW-1:0]     word_ev;
   logic [NW-1:0]     stat;
   logic [NW-1:0]     mask;
   logic [NW-1:0]     word_busy;
   logic [31:0]       next_rdata;
   logic              wr_phase;

   // One-hot register select; aliases above ADDR_W are not decoded
   function automatic ifsb_sel_t reg_sel(input logic [ADDR_W-1:0] a);
      ifsb_sel_t s;
      s = '0;
      case (a[7:0])
         `IFSB_OFS_WORD1: s[0] = 1'b1;
         `IFSB_OFS_WORD2: s[1] = 1'b1;
         `IFSB_OFS_WORD3: s[2] = 1'b1;
         `IFSB_OFS_WORD4: s[3] = 1'b1;
         `IFSB_OFS_STAT:  s[4] = 1'b1;
         `IFSB_OFS_MASK:  s[5] = 1'b1;
         `IFSB_OFS_PEND:  s[6] = 1'b1;
         default:         s    = '0;
      endcase
      return s;
   endfunction

   function automatic logic [15:0] impl_mask(input int w);
      logic [15:0] m;
      m = `IFSB_IMPL_WORD1;
      case (w)
         1:       m = `IFSB_IMPL_WORD2;
         2:       m = `IFSB_IMPL_WORD3;
         3:       m = `IFSB_IMPL_WORD4;
         default: m = `IFSB_IMPL_WORD1;
      endcase
      return m;
   endfunction

   // Event routing into flag positions
   always_comb begin
      for (int w = 0; w < NW; w++) begin
         ev_vec[w] = '0;
      end
      ev_vec[0][`IFSB_BIT_CMP]      = events.comparator_flag;    // R01
      ev_vec[0][`IFSB_BIT_I2C1_M]   = events.i2c1_master_flag;   // R01
      ev_vec[0][`IFSB_BIT_I2C1_S]   = events.i2c1_slave_flag;    // R01
      ev_vec[1][`IFSB_BIT_DMA4]     = events.dma_ch4_flag;       // R02
      ev_vec[1][`IFSB_BIT_PPORT]    = events.parallel_port_flag; // R02
      ev_vec[1][`IFSB_BIT_OC7]      = events.out_compare7_flag;  // R02
      ev_vec[1][`IFSB_BIT_OC6]      = events.out_compare6_flag;  // R02
      ev_vec[1][`IFSB_BIT_OC5]      = events.out_compare5_flag;  // R02
      ev_vec[1][`IFSB_BIT_IC6]      = events.in_capture6_flag;   // R03
      ev_vec[1][`IFSB_BIT_IC5]      = events.in_capture5_flag;   // R03
      ev_vec[1][`IFSB_BIT_IC4]      = events.in_capture4_flag;   // R03
      ev_vec[1][`IFSB_BIT_IC3]      = events.in_capture3_flag;   // R03
      ev_vec[1][`IFSB_BIT_DMA3]     = events.dma_ch3_flag;       // R03
      ev_vec[1][`IFSB_BIT_SPI2_EV]  = events.spi2_event_flag;    // R04
      ev_vec[1][`IFSB_BIT_SPI2_FLT] = events.spi2_fault_flag;    // R04
      ev_vec[2][`IFSB_BIT_RTC]      = events.calendar_clock_flag; // R05
      ev_vec[2][`IFSB_BIT_DMA5]     = events.dma_ch5_flag;       // R05
      ev_vec[2][`IFSB_BIT_EXT4]     = events.ext_pin4_flag;      // R05
      ev_vec[2][`IFSB_BIT_EXT3]     = events.ext_pin3_flag;      // R05
      ev_vec[2][`IFSB_BIT_I2C2_M]   = events.i2c2_master_flag;   // R06
      ev_vec[2][`IFSB_BIT_I2C2_S]   = events.i2c2_slave_flag;    // R06
      ev_vec[3][`IFSB_BIT_CTMU]     = events.charge_timer_flag;  // R07
      ev_vec[3][`IFSB_BIT_LVD]      = events.low_voltage_flag;   // R07
      ev_vec[3][`IFSB_BIT_CRC]      = events.crc_engine_flag;    // R07
      ev_vec[3][`IFSB_BIT_U2ERR]    = events.uart2_error_flag;   // R07
      ev_vec[3][`IFSB_BIT_U1ERR]    = events.uart1_error_flag;   // R07
   end

   // Bus phase tracking
   assign accept = hsel & htrans[1] & hready;

   always_comb begin
      next_state = IFSB_IDLE;
      case (state)
         IFSB_RDW: begin
            next_state = IFSB_RDD;
         end
         IFSB_IDLE, IFSB_WR, IFSB_RDD: begin
            if (accept && hwrite) begin
               next_state = IFSB_WR;
            end else if (accept) begin
               next_state = IFSB_RDW;
            end
         end
         default: begin
            next_state = IFSB_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= IFSB_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= '0;
      end else if (accept) begin
         addr_q <= haddr[ADDR_W-1:0];
      end
   end

   // The wait state lets a read see a write issued just before it
   assign hreadyout = (state != IFSB_RDW);
   assign hresp     = 1'b0;
   assign wr_phase  = (state == IFSB_WR);
   assign wsel      = wr_phase ? reg_sel(addr_q) : '0;
   assign rsel      = reg_sel(addr_q);

   // Flag words
   genvar gw;
   generate
      for (gw = 0; gw < NW; gw++) begin : g_word
         ifsb_flag_word #(
            .IMPL_MASK (impl_mask(gw))
         ) u_word (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .event_in  (ev_vec[gw]),
            .wr_en     (wsel[gw]),
            .wr_data   (hwdata[15:0]),
            .flags     (flag_q[gw]),
            .any_event (word_ev[gw])
         );
         assign word_busy[gw] = |flag_q[gw];
      end
   endgenerate

   assign pending.irq_flags_word1 = flag_q[0]; // R08
   assign pending.irq_flags_word2 = flag_q[1]; // R08
   assign pending.irq_flags_word3 = flag_q[2]; // R08
   assign pending.irq_flags_word4 = flag_q[3]; // R08

   // Sticky per-word event status; a new event beats a write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat <= `IFSB_STAT_RESET;
      end else begin
         stat <= word_ev | (stat & ~(wsel[4] ? hwdata[NW-1:0] : '0));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask <= `IFSB_MASK_RESET;
      end else if (wsel[5]) begin
         mask <= hwdata[NW-1:0];
      end
   end

   assign irq = |(stat & mask);

   // Read data is taken at the end of the wait state
   always_comb begin
      next_rdata = '0;
      case (1'b1)
         rsel[0]: next_rdata[15:0]   = flag_q[0]; // R09
         rsel[1]: next_rdata[15:0]   = flag_q[1]; // R09
         rsel[2]: next_rdata[15:0]   = flag_q[2]; // R09
         rsel[3]: next_rdata[15:0]   = flag_q[3]; // R09
         rsel[4]: next_rdata[NW-1:0] = stat;
         rsel[5]: next_rdata[NW-1:0] = mask;
         rsel[6]: next_rdata[NW-1:0] = word_busy;
         default: next_rdata         = '0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `IFSB_RDATA_RESET;
      end else if (state == IFSB_RDW) begin
         hrdata <= next_rdata; // R10
      end
   end

endmodule

// File: verification/ifsb_event_src.sv
// Purpose: Event sources beside the flag bank
// Assumes: Called just after a rising edge
// Notes:   Each request is a one-cycle pulse
module ifsb_event_src (
   input  wire logic      hclk,
   output ifsb_pkg::ifsb_events_s events
);
   timeunit 1ns;
   timeprecision 100ps;
   import ifsb_pkg::*;
   initial events = '0;
   // Sources only pulse; holding would hide stickiness
   task automatic fire(input logic [25:0] v);
      events <= v;
      @(posedge hclk);
      events <= '0;
   endtask
endmodule

// File: verification/ifsb_assertions.sv
// Purpose: Port checks of the flag bank
// Assumes: hready follows hreadyout
// Notes:   Bound below
module ifsb_assertions (
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hsel,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic                   hready,
   input wire logic                   hreadyout,
   input wire logic [31:0]            hrdata,
   input wire ifsb_pkg::ifsb_events_s events,
   input wire ifsb_pkg::ifsb_pend_s   pending,
   input wire logic                   irq
);
   import ifsb_pkg::*;
   logic take;
   logic wr_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign take = hsel && htrans[1] && hready;
   // Write data lands one edge after the take
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wr_q <= 1'b0;
      else
         wr_q <= take && hwrite;
   end
   a_map_word1: assert property (events.comparator_flag |=>
      pending.irq_flags_word1[2]) else $error("comparator flag");
   a_map_dma4: assert property (events.dma_ch4_flag |=>
      pending.irq_flags_word2[14]) else $error("dma4 flag");
   a_map_dma3: assert property (events.dma_ch3_flag |=>
      pending.irq_flags_word2[4]) else $error("dma3 flag");
   a_map_spi2: assert property (events.spi2_fault_flag |=>
      pending.irq_flags_word2[0]) else $error("spi2 fault flag");
   a_map_clock: assert property (events.calendar_clock_flag |=>
      pending.irq_flags_word3[14]) else $error("clock flag");
   a_map_i2c2: assert property (events.i2c2_slave_flag |=>
      pending.irq_flags_word3[1]) else $error("i2c2 slave flag");
   a_map_crc: assert property (events.crc_engine_flag |=>
      pending.irq_flags_word4[3]) else $error("crc flag");
   a_unimpl_zero: assert property (
      (pending & 64'hDEF1_9F99_900C_FFF8) == 64'h0) else $error("unused bit");
   a_flag_hold: assert property (!(|events) && !wr_q |=>
      $stable(pending)) else $error("flag moved alone");
   a_reset_clear: assert property ($rose(hresetn) |->
      pending == '0 && !irq) else $error("not clear after reset");
   a_read_wait: assert property (take && !hwrite |=>
      !hreadyout ##1 hreadyout) else $error("read wait wrong");
endmodule

bind ifsb_top ifsb_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .events(events),
   .pending(pending), .irq(irq));

// File: verification/test_interrupt_flag_status_bank.sv
// Purpose: Self-checking bench of the flag bank
// Assumes: AHB-Lite master in tasks, one clock
// Notes:   Random values from a fixed seed
module test_interrupt_flag_status_bank;
   timeunit 1ns;
   timeprecision 100ps;
   import ifsb_pkg::*;
   logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [1:0]   htrans;
   logic [31:0]  haddr, hwdata, hrdata, r;
   logic [63:0]  m, impl;
   ifsb_events_s events;
   ifsb_pend_s   pending;
   int           fails, n_checks, cyc, seed, w;
   // Bit of each source in the 64-bit view, struct order
   int tbl [26] = '{2, 1, 0, 30, 29, 27, 26, 25, 24, 23, 22, 21, 20, 17,
                    16, 46, 45, 38, 37, 34, 33, 61, 56, 51, 50, 49};
   assign hready = hreadyout;
   ifsb_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .events(events),
      .pending(pending), .irq(irq));
   ifsb_event_src src (.hclk(hclk), .events(events));
   always #12.5 hclk = ~hclk;
   function automatic logic [63:0] map(input logic [25:0] v);
      map = '0;
      for (int i = 0; i < 26; i++)
         if (v[25 - i])
            map[tbl[i]] = 1'b1;
   endfunction
   task automatic check(input string nm, input logic [63:0] e, g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Optional event lands in the write data phase
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [25:0] ev);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      if (ev !== '0)
         fork src.fire(ev); join_none
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      check("hresp", 0, hresp);
      if (wr && a < 8'h10)
         m[a[3:2]*16 +: 16] = d[15:0] & impl[a[3:2]*16 +: 16];
      m = m | map(ev);
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      seed = 2718;
      m = '0;
      impl = map('1);
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      for (w = 0; w < 8; w++) begin
         bus(0, 8'(w * 4), 0, 0);
         check("reset read", 0, r);
      end
      for (w = 0; w < 26; w++) begin
         src.fire(26'h1 << (25 - w));
         @(posedge hclk);
         m = 64'h1 << tbl[w];
         check("pending", m, pending);
         bus(0, 8'(tbl[w] / 16 * 4), 0, 0);
         check("flag word", 64'h1 << (tbl[w] % 16), r);
         bus(1, 8'(tbl[w] / 16 * 4), 0, 0);
      end
      @(posedge hclk);
      check("cleared", 0, pending);
      bus(1, 8'h14, 32'h2, 0);
      @(posedge hclk);
      check("irq on", 1, irq);
      bus(1, 8'h10, 32'h2, 0);
      @(posedge hclk);
      check("irq off", 0, irq);
      bus(0, 8'h10, 0, 0);
      check("status", 32'hD, r);
      bus(0, 8'h14, 0, 0);
      check("mask", 32'h2, r);
      repeat (20) begin
         w = $unsigned($random(seed)) % 4;
         bus(1, 8'(w * 4), $random(seed), 0);
         bus(0, 8'(w * 4), 0, 0);
         check("word rw", m[w*16 +: 16], r);
      end
      bus(1, 8'h04, 32'hFFFF, 0);
      bus(1, 8'h04, 0, 26'h1 << 22);
      @(posedge hclk);
      check("set wins", m, pending);
      // Unmapped write must leave every flag alone
      bus(1, 8'h1C, 32'hFFFF, 0);
      bus(0, 8'h18, 0, 0);
      check("busy", {|m[63:48], |m[47:32], |m[31:16], |m[15:0]}, r);
      repeat (30) begin
         r = $random(seed);
         src.fire(r[25:0]);
         m = m | map(r[25:0]);
         @(posedge hclk);
         check("events", m, pending);
      end
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("reset again", 0, pending);
      // Bus must answer again after a mid-run reset
      for (w = 0; w < 7; w++) begin
         bus(0, 8'(w * 4), 0, 0);
         check("reset read", 0, r);
      end
      summarize();
   end
endmodule
